// ===== design/xse_defs.svh
// Constants for the extended stack instruction executor
`ifndef XSE_DEFS_SVH
`define XSE_DEFS_SVH
`define XSE_OPC_PUSH 8'hea
`define XSE_OPC_SUBP 8'he9
`define XSE_SEL_RET 2'h3
`define XSE_SEL_STACK 2'h2
`define XSE_PH_Q1 2'h0
`define XSE_PH_Q4 2'h3
`define XSE_PH_STEP 2'h1
`define XSE_PTR_RST 12'h000
`define XSE_DEC_ONE 12'h001
`define XSE_LIT_RST 8'h00
`define XSE_PC_RST 21'h000000
`define XSE_OPC_HI 15
`define XSE_OPC_LO 8
`define XSE_SEL_HI 7
`define XSE_SEL_LO 6
`define XSE_LIT_HI 7
`define XSE_LIT_LO 0
`endif

// ===== design/xse_pkg.sv
// Types for the extended stack instruction executor
package xse_pkg;
	typedef enum logic [1:0] {OP_NONE, OP_PUSH, OP_SUBP, OP_SUBRET} xse_op_t;
	typedef enum logic {CYC_EXEC, CYC_NOP} xse_cyc_t;
endpackage

// ===== design/xse_phase.sv
// Four-phase instruction cycle counter
`timescale 1ns/1ps
`include "xse_defs.svh"
module xse_phase (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	output logic [1:0] phase_o
);
	logic [1:0] phase_r;
	logic [1:0] phase_nxt;

	always_comb begin
		phase_nxt = 2'(phase_r + `XSE_PH_STEP);
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			phase_r <= `XSE_PH_Q1;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	assign phase_o = phase_r;
endmodule // xse_phase

// ===== design/xse_exec.sv
// Decode and execute of push-literal, pointer subtract and subtract-and-return
// How it works
// - Push-literal opcode writes its low-byte literal where the stack pointer points
// - Push-literal then decrements the stack pointer by one, one cycle, no flags
// - Selector 0 to 2 subtracts the 6-bit literal from that pointer, one cycle
// - Selector 3 means subtract-and-return, acting only on the stack pointer
// - Subtract-and-return subtracts from stack pointer, then loads PC from return stack top
// - Subtract-and-return takes two cycles; the second is a no-operation
// - Extended opcodes are decoded only while the extended set enable is one
`timescale 1ns/1ps
`include "xse_defs.svh"
module xse_exec #(
	parameter int ADDR_W = 12,
	parameter int LIT_W = 6,
	parameter int PC_W = 21
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic instr_valid_i,
	input wire logic [15:0] instr_word_i,
	input wire logic extended_set_enable_i,
	input wire logic [PC_W-1:0] return_stack_top_i,
	input wire logic ptr_wr_i,
	input wire logic [1:0] ptr_sel_i,
	input wire logic [ADDR_W-1:0] ptr_wdata_i,
	output logic [1:0] phase_o,
	output logic mem_wr_o,
	output logic [ADDR_W-1:0] mem_addr_o,
	output logic [7:0] mem_data_o,
	output logic pc_load_o,
	output logic [PC_W-1:0] pc_value_o,
	output logic nop_cycle_o,
	output logic [ADDR_W-1:0] ptr0_o,
	output logic [ADDR_W-1:0] ptr1_o,
	output logic [ADDR_W-1:0] software_stack_pointer_o
);
	logic [1:0] phase;
	xse_pkg::xse_op_t op_r, op_nxt;
	xse_pkg::xse_cyc_t cyc_r, cyc_nxt;
	logic [7:0] lit_r, lit_nxt;
	logic [1:0] sel_r, sel_nxt;
	logic [ADDR_W-1:0] ptr_r [3];
	logic [ADDR_W-1:0] ptr_nxt [3];
	logic mem_wr_r, mem_wr_nxt;
	logic [ADDR_W-1:0] mem_addr_r, mem_addr_nxt;
	logic [7:0] mem_data_r, mem_data_nxt;
	logic pc_load_r, pc_load_nxt;
	logic [PC_W-1:0] pc_value_r, pc_value_nxt;
	logic nop_r, nop_nxt;

	xse_phase u_phase (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.phase_o(phase)
	);

	function automatic xse_pkg::xse_op_t decode_op(input logic vld, input logic [15:0] w,
			input logic en);
		decode_op = xse_pkg::OP_NONE;
		if (vld && en) begin
			if (w[`XSE_OPC_HI:`XSE_OPC_LO] == `XSE_OPC_PUSH) begin
				decode_op = xse_pkg::OP_PUSH;
			end else if (w[`XSE_OPC_HI:`XSE_OPC_LO] == `XSE_OPC_SUBP) begin
				if (w[`XSE_SEL_HI:`XSE_SEL_LO] == `XSE_SEL_RET) begin
					decode_op = xse_pkg::OP_SUBRET;
				end else begin
					decode_op = xse_pkg::OP_SUBP;
				end
			end
		end
	endfunction

	function automatic logic [ADDR_W-1:0] sub_ptr(input logic [ADDR_W-1:0] p,
			input logic [ADDR_W-1:0] amt);
		sub_ptr = ADDR_W'(p - amt);
	endfunction

	function automatic logic [ADDR_W-1:0] lit_amt(input logic [7:0] l);
		lit_amt = ADDR_W'(l[LIT_W-1:0]);
	endfunction

	always_comb begin
		op_nxt = op_r;
		cyc_nxt = cyc_r;
		lit_nxt = lit_r;
		sel_nxt = sel_r;
		ptr_nxt = ptr_r;
		mem_wr_nxt = 1'b0;
		mem_addr_nxt = mem_addr_r;
		mem_data_nxt = mem_data_r;
		pc_load_nxt = 1'b0;
		pc_value_nxt = pc_value_r;
		nop_nxt = nop_r;
		if (ptr_wr_i && ptr_sel_i != `XSE_SEL_RET) begin
			ptr_nxt[ptr_sel_i] = ptr_wdata_i;
		end
		if (phase == `XSE_PH_Q1) begin
			if (cyc_r == xse_pkg::CYC_EXEC) begin
				op_nxt = decode_op(instr_valid_i, instr_word_i, extended_set_enable_i);
				lit_nxt = instr_word_i[`XSE_LIT_HI:`XSE_LIT_LO];
				sel_nxt = instr_word_i[`XSE_SEL_HI:`XSE_SEL_LO];
			end else begin
				op_nxt = xse_pkg::OP_NONE;
			end
		end
		if (phase == `XSE_PH_Q4) begin
			unique case (op_r)
				xse_pkg::OP_PUSH: begin
					mem_wr_nxt = 1'b1;
					mem_addr_nxt = ptr_r[`XSE_SEL_STACK];
					mem_data_nxt = lit_r;
					ptr_nxt[`XSE_SEL_STACK] = sub_ptr(ptr_r[`XSE_SEL_STACK], `XSE_DEC_ONE);
				end
				xse_pkg::OP_SUBP: begin
					ptr_nxt[sel_r] = sub_ptr(ptr_r[sel_r], lit_amt(lit_r));
				end
				xse_pkg::OP_SUBRET: begin
					ptr_nxt[`XSE_SEL_STACK] = sub_ptr(ptr_r[`XSE_SEL_STACK], lit_amt(lit_r));
					pc_load_nxt = 1'b1;
					pc_value_nxt = return_stack_top_i;
					cyc_nxt = xse_pkg::CYC_NOP;
					nop_nxt = 1'b1;
				end
				xse_pkg::OP_NONE: begin
					if (cyc_r == xse_pkg::CYC_NOP) begin
						cyc_nxt = xse_pkg::CYC_EXEC;
						nop_nxt = 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			op_r <= xse_pkg::OP_NONE;
			cyc_r <= xse_pkg::CYC_EXEC;
			lit_r <= `XSE_LIT_RST;
			sel_r <= `XSE_PH_Q1;
			ptr_r <= '{default: `XSE_PTR_RST};
			mem_wr_r <= 1'b0;
			mem_addr_r <= `XSE_PTR_RST;
			mem_data_r <= `XSE_LIT_RST;
			pc_load_r <= 1'b0;
			pc_value_r <= `XSE_PC_RST;
			nop_r <= 1'b0;
		end else begin
			op_r <= op_nxt;
			cyc_r <= cyc_nxt;
			lit_r <= lit_nxt;
			sel_r <= sel_nxt;
			ptr_r <= ptr_nxt;
			mem_wr_r <= mem_wr_nxt;
			mem_addr_r <= mem_addr_nxt;
			mem_data_r <= mem_data_nxt;
			pc_load_r <= pc_load_nxt;
			pc_value_r <= pc_value_nxt;
			nop_r <= nop_nxt;
		end
	end

	assign phase_o = phase;
	assign mem_wr_o = mem_wr_r;
	assign mem_addr_o = mem_addr_r;
	assign mem_data_o = mem_data_r;
	assign pc_load_o = pc_load_r;
	assign pc_value_o = pc_value_r;
	assign nop_cycle_o = nop_r;
	assign ptr0_o = ptr_r[0];
	assign ptr1_o = ptr_r[1];
	assign software_stack_pointer_o = ptr_r[`XSE_SEL_STACK];

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	// Execute phase of push and subtract-and-return, and the no-op cycle after a return
	sequence s_push_exec;
		phase == `XSE_PH_Q4 && op_r == xse_pkg::OP_PUSH;
	endsequence
	sequence s_ret_exec;
		phase == `XSE_PH_Q4 && op_r == xse_pkg::OP_SUBRET;
	endsequence
	sequence s_nop_cycle;
		(nop_cycle_o && !mem_wr_o) ##1 (nop_cycle_o && !mem_wr_o && !pc_load_o) [*3];
	endsequence

	property p_push_write;
		s_push_exec |=> mem_wr_o && mem_addr_o == $past(ptr_r[2])
			&& mem_data_o == $past(lit_r);
	endproperty
	a_push_write: assert property (p_push_write) else $error("push write wrong");

	property p_push_dec;
		(s_push_exec and !ptr_wr_i)
			|=> software_stack_pointer_o == 12'($past(ptr_r[2]) - 12'h001);
	endproperty
	a_push_dec: assert property (p_push_dec) else $error("push decrement wrong");

	property p_subp;
		phase == `XSE_PH_Q4 && op_r == xse_pkg::OP_SUBP && sel_r == 2'h0 && !ptr_wr_i
			|=> ptr0_o == 12'($past(ptr_r[0]) - 12'($past(lit_r[5:0])));
	endproperty
	a_subp: assert property (p_subp) else $error("pointer subtract wrong");

	property p_ret_only_stack;
		(s_ret_exec and !ptr_wr_i) |=> ptr0_o == $past(ptr_r[0]) && ptr1_o == $past(ptr_r[1]);
	endproperty
	a_ret_only_stack: assert property (p_ret_only_stack) else $error("return touched pointer");

	property p_ret_pc;
		s_ret_exec |=> pc_load_o && pc_value_o == $past(return_stack_top_i)
			&& software_stack_pointer_o == 12'($past(ptr_r[2]) - 12'($past(lit_r[5:0])));
	endproperty
	a_ret_pc: assert property (p_ret_pc) else $error("return load wrong");

	property p_ret_nop;
		s_ret_exec |=> s_nop_cycle ##1 !nop_cycle_o;
	endproperty
	a_ret_nop: assert property (p_ret_nop) else $error("second cycle not a no-operation");

	property p_disabled;
		phase == `XSE_PH_Q1 && !extended_set_enable_i |=> op_r == xse_pkg::OP_NONE;
	endproperty
	a_disabled: assert property (p_disabled) else $error("decoded while disabled");

	property p_wrap;
		(s_push_exec and (ptr_r[2] == 12'h000 && !ptr_wr_i))
			|=> software_stack_pointer_o == 12'hfff;
	endproperty
	a_wrap: assert property (p_wrap) else $error("pointer did not wrap");
endmodule // xse_exec

// ===== test/xse_prog_mem.sv
// Program memory model handing one instruction word to the core at Q1
`timescale 1ns/1ps
module xse_prog_mem (
	input wire logic ref_clk_i,
	input wire logic [1:0] phase_i,
	input wire logic load_i,
	input wire logic [15:0] load_word_i,
	output logic instr_valid_o,
	output logic [15:0] instr_word_o
);
	logic ld;
	logic [15:0] w;
	initial begin
		instr_valid_o = 1'b0;
		instr_word_o = 16'h0000;
	end
	// Word valid only in Q1; otherwise the bus toggles instead of holding
	always @(posedge ref_clk_i) begin
		ld = load_i;
		w = load_word_i;
		#1;
		if (ld && phase_i == 2'h0) begin
			instr_valid_o = 1'b1;
			instr_word_o = w;
		end else begin
			instr_valid_o = 1'b0;
			instr_word_o = ~instr_word_o;
		end
	end
endmodule // xse_prog_mem

// ===== test/extended_stack_instr_exec_bench.sv
// Self-checking bench for the extended stack instruction executor
`timescale 1ns/1ps
module extended_stack_instr_exec_bench;
	logic ref_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic extended_set_enable_i = 1'b1;
	logic [20:0] return_stack_top_i = 21'h1abcde;
	logic ptr_wr_i = 1'b0;
	logic [1:0] ptr_sel_i = 2'h0;
	logic [11:0] ptr_wdata_i = 12'h000;
	logic load = 1'b0;
	logic [15:0] load_word = 16'h0000;
	logic instr_valid_i, mem_wr_o, pc_load_o, nop_cycle_o;
	logic [15:0] instr_word_i;
	logic [1:0] phase_o;
	logic [11:0] mem_addr_o, ptr0_o, ptr1_o, software_stack_pointer_o;
	logic [7:0] mem_data_o;
	logic [20:0] pc_value_o;
	int fails = 0;
	int total_checks = 0;
	xse_exec dut_u (.ref_clk_i, .rst_b_i, .instr_valid_i, .instr_word_i, .extended_set_enable_i,
		.return_stack_top_i, .ptr_wr_i, .ptr_sel_i, .ptr_wdata_i, .phase_o, .mem_wr_o,
		.mem_addr_o, .mem_data_o, .pc_load_o, .pc_value_o, .nop_cycle_o, .ptr0_o, .ptr1_o,
		.software_stack_pointer_o);
	xse_prog_mem mem_u (.ref_clk_i(ref_clk_i), .phase_i(phase_o), .load_i(load),
		.load_word_i(load_word), .instr_valid_o(instr_valid_i), .instr_word_o(instr_word_i));
	initial begin
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	task automatic final_report();
		$display("fails=%0d total_checks=%0d", fails, total_checks);
		if (fails == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [20:0] got, input logic [20:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic step();
		@(posedge ref_clk_i);
		#1;
	endtask
	task automatic wrp(input logic [1:0] s, input logic [11:0] d);
		ptr_sel_i = s;
		ptr_wdata_i = d;
		ptr_wr_i = 1'b1;
		step();
		ptr_wr_i = 1'b0;
		step();
	endtask
	// Issues one word and returns just after the edge that ends its executing Q4
	task automatic issue(input logic [15:0] w);
		int n;
		n = 0;
		while (phase_o !== 2'h3) begin
			step();
			n++;
			if (n > 8) begin
				fails++;
				final_report();
			end
		end
		load = 1'b1;
		load_word = w;
		step();
		load = 1'b0;
		repeat (4) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic t_push();
		wrp(2'h2, 12'h1ec);
		issue(16'hea08);
		chk(mem_wr_o, 1'b1);
		chk(mem_addr_o, 12'h1ec);
		chk(mem_data_o, 8'h08);
		chk(software_stack_pointer_o, 12'h1eb);
		step();
		chk(mem_wr_o, 1'b0);
		wrp(2'h2, 12'h000);
		issue(16'hea5a);
		chk(mem_addr_o, 12'h000);
		chk(software_stack_pointer_o, 12'hfff);
	endtask
	task automatic t_sub();
		for (int s = 0; s < 3; s++) begin
			wrp(s[1:0], 12'h3ff);
			issue({8'he9, s[1:0], 6'h23});
			chk(s == 0 ? ptr0_o : s == 1 ? ptr1_o : software_stack_pointer_o, 12'h3dc);
		end
		wrp(2'h0, 12'h010);
		issue(16'he93f);
		chk(ptr0_o, 12'hfd1);
	endtask
	task automatic t_ret();
		wrp(2'h0, 12'h111);
		wrp(2'h2, 12'h3ff);
		issue(16'he9e3);
		chk(pc_load_o, 1'b1);
		chk(pc_value_o, return_stack_top_i);
		chk(software_stack_pointer_o, 12'h3dc);
		chk(ptr0_o, 12'h111);
		repeat (3) step();
		chk(nop_cycle_o, 1'b1);
		chk(pc_load_o, 1'b0);
		step();
		chk(nop_cycle_o, 1'b0);
	endtask
	// Push word lands on the no-op Q1 after a return and must be dropped
	task automatic t_skip();
		int n;
		n = 0;
		wrp(2'h2, 12'h3ff);
		while (phase_o !== 2'h3) begin
			step();
			n++;
			if (n > 8) begin
				fails++;
				final_report();
			end
		end
		load = 1'b1;
		load_word = 16'he9e3;
		step();
		load_word = 16'hea55;
		repeat (4) step();
		load = 1'b0;
		chk(pc_load_o, 1'b1);
		chk(nop_cycle_o, 1'b1);
		repeat (4) step();
		chk(mem_wr_o, 1'b0);
		chk(software_stack_pointer_o, 12'h3dc);
		chk(nop_cycle_o, 1'b0);
	endtask
	// Mid-run reset, then a push from the released phase counter
	task automatic t_rst();
		rst_b_i = 1'b0;
		step();
		chk(phase_o, 2'h0);
		chk(software_stack_pointer_o, 12'h000);
		chk(mem_wr_o, 1'b0);
		chk(nop_cycle_o, 1'b0);
		rst_b_i = 1'b1;
		step();
		chk(phase_o, 2'h1);
		wrp(2'h2, 12'h0ff);
		issue(16'hea01);
		chk(mem_addr_o, 12'h0ff);
		chk(mem_data_o, 8'h01);
		chk(software_stack_pointer_o, 12'h0fe);
	endtask
	task automatic t_off();
		extended_set_enable_i = 1'b0;
		wrp(2'h2, 12'h200);
		issue(16'hea77);
		chk(mem_wr_o, 1'b0);
		chk(software_stack_pointer_o, 12'h200);
		extended_set_enable_i = 1'b1;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk_i);
		#1;
		rst_b_i = 1'b1;
		t_push();
		t_sub();
		t_ret();
		t_skip();
		t_off();
		t_rst();
		final_report();
	end
endmodule // extended_stack_instr_exec_bench
